// file: mgmt_regs_pkg.sv
// Shared constants and types for the management register group
package mgmt_regs_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [4:0] ID_HIGH_ADDR = 5'h02;
  localparam logic [4:0] ID_LOW_ADDR = 5'h03;
  localparam logic [4:0] OFFER_ADDR = 5'h04;

  // ****************************************
  // Identity values (arbitrary, neutral)
  // ****************************************
  localparam logic [15:0] VENDOR_ID_HIGH = 16'h1234;
  localparam logic [5:0] VENDOR_ID_LOW_BITS = 6'h15;
  localparam logic [5:0] MODEL_NUMBER = 6'h05;
  localparam logic [3:0] REVISION_NUMBER = 4'h2;

  // ****************************************
  // Offer register fields
  // ****************************************
  localparam int NEXT_PAGE_BIT = 15;
  localparam int RESERVED_BIT = 14;
  localparam int REMOTE_FAULT_BIT = 13;
  localparam int EXT_PAGES_BIT = 12;
  localparam int ASYM_PAUSE_BIT = 11;
  localparam int SYM_PAUSE_BIT = 10;
  localparam int FOUR_PAIR_BIT = 9;
  localparam int SPEED_MSB = 8;
  localparam int SPEED_LSB = 5;
  localparam int SELECTOR_MSB = 4;
  localparam logic [15:0] OFFER_RESET = 16'h01e1;
  localparam logic [15:0] OFFER_WRITE_MASK = 16'hbde0;
  localparam logic [4:0] SELECTOR_IEEE = 5'h01;

  // ****************************************
  // Serial management frame
  // ****************************************
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [4:0] OP_LAST = 5'h01;
  localparam logic [4:0] FIELD_LAST = 5'h04;
  localparam logic [4:0] TA_LAST = 5'h01;
  localparam logic [4:0] DATA_LAST = 5'h0f;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_OP = 3'b010,
    ST_PHY = 3'b011,
    ST_REG = 3'b100,
    ST_TA = 3'b101,
    ST_DATA = 3'b110
  } frame_state_t;

endpackage

// file: reg_access_if.sv
// Register access path between the frame engine and the register banks
`timescale 1ns/100ps
`default_nettype none
interface reg_access_if;
  logic [4:0] addr;
  logic wr;
  logic [15:0] wdata;
  logic strap_load;
  logic [3:0] strap;
  logic [15:0] id_rdata;
  logic [15:0] offer_rdata;
  logic [15:0] offer;

  modport engine (
    output addr, wr, wdata, strap_load, strap,
    input id_rdata, offer_rdata, offer
  );
  modport ident (
    input addr,
    output id_rdata
  );
  modport offer_side (
    input addr, wr, wdata, strap_load, strap,
    output offer_rdata, offer
  );
endinterface
`default_nettype wire

// file: ident_bank.sv
// Read-only identifier registers
`timescale 1ns/100ps
`default_nettype none
module ident_bank
  import mgmt_regs_pkg::*;
(
  reg_access_if.ident rif
);

  always_comb begin
    unique case (rif.addr)
      ID_HIGH_ADDR: rif.id_rdata = VENDOR_ID_HIGH;
      ID_LOW_ADDR: rif.id_rdata = {VENDOR_ID_LOW_BITS,
                                   MODEL_NUMBER, REVISION_NUMBER};
      default: rif.id_rdata = 16'h0000;
    endcase
  end

endmodule
`default_nettype wire

// file: offer_bank.sv
// Negotiation offer register with strap-dependent default
`timescale 1ns/100ps
`default_nettype none
module offer_bank
  import mgmt_regs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  reg_access_if.offer_side rif
);

  logic [15:0] offer_q;
  logic [15:0] offer_d;

  always_comb begin
    offer_d = offer_q;
    if (rif.strap_load) begin
      offer_d[SPEED_MSB:SPEED_LSB] = rif.strap;
    end else if (rif.wr && rif.addr == OFFER_ADDR) begin
      // Masked write keeps fixed bits untouched
      offer_d = (offer_q & ~OFFER_WRITE_MASK) | (rif.wdata & OFFER_WRITE_MASK);
    end
    offer_d[RESERVED_BIT] = 1'b0;
    offer_d[FOUR_PAIR_BIT] = 1'b0;
    offer_d[SELECTOR_MSB:0] = SELECTOR_IEEE;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      offer_q <= OFFER_RESET;
    end else begin
      offer_q <= offer_d;
    end
  end

  assign rif.offer = offer_q;
  assign rif.offer_rdata = (rif.addr == OFFER_ADDR) ? offer_q : 16'h0000;

  // ****************************************
  // Checks
  // ****************************************
  fixed_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
    offer_q[FOUR_PAIR_BIT] == 1'b0 && offer_q[RESERVED_BIT] == 1'b0)
    else $error("Fixed offer bit set");
  selector_fixed_a: assert property (@(posedge mclk) disable iff (!rst_n)
    offer_q[SELECTOR_MSB:0] == SELECTOR_IEEE)
    else $error("Selector not IEEE");
  strap_default_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n && rif.strap_load |=> offer_q[SPEED_MSB:SPEED_LSB] == $past(rif.strap))
    else $error("Strap default not loaded");
  next_page_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rif.wr && rif.addr == OFFER_ADDR && !rif.strap_load)
    |=> offer_q[NEXT_PAGE_BIT] == $past(rif.wdata[NEXT_PAGE_BIT]))
    else $error("Next page bit not written");
  fault_ext_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rif.wr && rif.addr == OFFER_ADDR && !rif.strap_load)
    |=> offer_q[REMOTE_FAULT_BIT:EXT_PAGES_BIT]
        == $past(rif.wdata[REMOTE_FAULT_BIT:EXT_PAGES_BIT]))
    else $error("Fault or extended page bit not written");
  pause_speed_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rif.wr && rif.addr == OFFER_ADDR && !rif.strap_load)
    |=> offer_q[ASYM_PAUSE_BIT:SYM_PAUSE_BIT] == $past(rif.wdata[ASYM_PAUSE_BIT:SYM_PAUSE_BIT])
        && offer_q[SPEED_MSB:SPEED_LSB] == $past(rif.wdata[SPEED_MSB:SPEED_LSB]))
    else $error("Ability bits not written");

endmodule
`default_nettype wire

// file: phy_mgmt_regs.sv
// Serial management slave with identifier and negotiation offer registers
//
// Overview of operation
// - First identifier register shows vendor bits 3-18
// - Second identifier top six bits: vendor bits 19-24
// - Model number bits 9:4, revision bits 3:0
// - Offer bit 15 requests next page exchange
// - Offer bit 13 carries local remote fault
// - Offer bit 12 advertises extended next pages
// - Bits 11:5 abilities; 11 asym, 10 sym pause
// - Offer bit 9 read-only, always zero
// - Bits 8:5 speed/duplex offers, all ones in reset, strap value after release
// - Selector bits 4:0 fixed at one
// - Offer reset default follows sampled strap pins
// - Completion flag output follows an_done one mclk later, not held
`timescale 1ns/100ps
`default_nettype none
module phy_mgmt_regs
  import mgmt_regs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic [4:0] phy_address,
  input wire logic [3:0] cfg_speed_offer,
  input wire logic an_done,
  output logic [15:0] negotiation_offer,
  output logic negotiation_complete
);

  reg_access_if rif ();

  // ****************************************
  // Register banks
  // ****************************************
  ident_bank u_ident (
    .rif(rif.ident)
  );

  offer_bank u_offer (
    .mclk(mclk),
    .rst_n(rst_n),
    .rif(rif.offer_side)
  );

  // ****************************************
  // Strap capture and status
  // ****************************************
  logic strap_load_q;
  logic strap_load_d;
  logic complete_q;
  logic complete_d;

  always_comb begin
    // One load pulse on the first edge after reset release
    strap_load_d = 1'b0;
    complete_d = an_done;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_load_q <= 1'b1;
      complete_q <= 1'b0;
    end else begin
      strap_load_q <= strap_load_d;
      complete_q <= complete_d;
    end
  end

  // Strap pins are taken at the first edge after release
  assign rif.strap_load = strap_load_q;
  assign rif.strap = cfg_speed_offer;
  assign negotiation_complete = complete_q;
  assign negotiation_offer = rif.offer;

  // ****************************************
  // Frame engine
  // ****************************************
  frame_state_t state_q;
  frame_state_t state_d;
  logic mdc_prev_q;
  logic mdc_rise;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [15:0] shift_q;
  logic [15:0] shift_d;
  logic [15:0] out_q;
  logic [15:0] out_d;
  logic seen_one_q;
  logic seen_one_d;
  logic read_q;
  logic read_d;
  logic match_q;
  logic match_d;
  logic [4:0] addr_q;
  logic [4:0] addr_d;
  logic wr_q;
  logic wr_d;
  logic [15:0] wdata_q;
  logic [15:0] wdata_d;
  logic mdio_o_q;
  logic mdio_o_d;
  logic mdio_oe_q;
  logic mdio_oe_d;
  logic [1:0] op_bits;
  logic [4:0] field_bits;

  // Management clock is sampled, not used as a clock
  assign mdc_rise = mdc & ~mdc_prev_q;
  assign op_bits = {shift_q[0], mdio_i};
  assign field_bits = {shift_q[3:0], mdio_i};

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    out_d = out_q;
    seen_one_d = seen_one_q;
    read_d = read_q;
    match_d = match_q;
    addr_d = addr_q;
    wr_d = 1'b0;
    wdata_d = wdata_q;
    mdio_o_d = mdio_o_q;
    mdio_oe_d = mdio_oe_q;
    if (mdc_rise) begin
      shift_d = {shift_q[14:0], mdio_i};
      unique case (state_q)
        ST_IDLE: begin
          // Short preamble accepted: one 1 before the start 0
          seen_one_d = mdio_i;
          if (!mdio_i && seen_one_q) begin
            state_d = ST_START;
          end
        end
        ST_START: begin
          if (mdio_i) begin
            state_d = ST_OP;
            cnt_d = OP_LAST;
          end else begin
            state_d = ST_IDLE;
          end
        end
        ST_OP: begin
          if (cnt_q == 5'h00) begin
            read_d = (op_bits == OP_READ);
            if (op_bits == OP_READ || op_bits == OP_WRITE) begin
              state_d = ST_PHY;
              cnt_d = FIELD_LAST;
            end else begin
              state_d = ST_IDLE;
            end
          end else begin
            cnt_d = cnt_q - 5'h01;
          end
        end
        ST_PHY: begin
          if (cnt_q == 5'h00) begin
            match_d = (field_bits == phy_address);
            state_d = ST_REG;
            cnt_d = FIELD_LAST;
          end else begin
            cnt_d = cnt_q - 5'h01;
          end
        end
        ST_REG: begin
          if (cnt_q == 5'h00) begin
            addr_d = field_bits;
            state_d = ST_TA;
            cnt_d = TA_LAST;
          end else begin
            cnt_d = cnt_q - 5'h01;
          end
        end
        ST_TA: begin
          if (cnt_q != 5'h00) begin
            cnt_d = 5'h00;
            if (read_q && match_q) begin
              // Take the pin for the second turnaround bit
              mdio_oe_d = 1'b1;
              mdio_o_d = 1'b0;
              out_d = rif.id_rdata | rif.offer_rdata;
            end
          end else begin
            state_d = ST_DATA;
            cnt_d = DATA_LAST;
            if (read_q && match_q) begin
              mdio_o_d = out_q[15];
              out_d = {out_q[14:0], 1'b0};
            end
          end
        end
        ST_DATA: begin
          if (cnt_q == 5'h00) begin
            state_d = ST_IDLE;
            seen_one_d = 1'b0;
            mdio_oe_d = 1'b0;
            mdio_o_d = 1'b0;
            if (!read_q) begin
              // Address mismatch still runs the frame, but drops the write
              wr_d = match_q;
              wdata_d = {shift_q[14:0], mdio_i};
            end
          end else begin
            cnt_d = cnt_q - 5'h01;
            if (read_q && match_q) begin
              mdio_o_d = out_q[15];
              out_d = {out_q[14:0], 1'b0};
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      // Idle-high level, so a parked mdc gives no false rise after reset
      mdc_prev_q <= 1'b1;
      cnt_q <= 5'h00;
      shift_q <= 16'h0000;
      out_q <= 16'h0000;
      seen_one_q <= 1'b0;
      read_q <= 1'b0;
      match_q <= 1'b0;
      addr_q <= 5'h00;
      wr_q <= 1'b0;
      wdata_q <= 16'h0000;
      mdio_o_q <= 1'b0;
      mdio_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mdc_prev_q <= mdc;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      out_q <= out_d;
      seen_one_q <= seen_one_d;
      read_q <= read_d;
      match_q <= match_d;
      addr_q <= addr_d;
      wr_q <= wr_d;
      wdata_q <= wdata_d;
      mdio_o_q <= mdio_o_d;
      mdio_oe_q <= mdio_oe_d;
    end
  end

  assign rif.addr = addr_q;
  assign rif.wr = wr_q;
  assign rif.wdata = wdata_q;
  assign mdio_o = mdio_o_q;
  assign mdio_oe = mdio_oe_q;

  // ****************************************
  // Checks
  // ****************************************
  logic read_load;
  assign read_load = mdc_rise && state_q == ST_TA && cnt_q != 5'h00 && read_q && match_q;

  id_high_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (read_load && addr_q == ID_HIGH_ADDR) |=> out_q == VENDOR_ID_HIGH)
    else $error("Identifier high read wrong");
  id_low_oui_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (read_load && addr_q == ID_LOW_ADDR) |=> out_q[15:10] == VENDOR_ID_LOW_BITS)
    else $error("Identifier low vendor bits wrong");
  model_rev_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (read_load && addr_q == ID_LOW_ADDR)
    |=> out_q[9:0] == {MODEL_NUMBER, REVISION_NUMBER})
    else $error("Model or revision wrong");
  offer_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (read_load && addr_q == OFFER_ADDR)
    |=> out_q[RESERVED_BIT] == 1'b0 && out_q[FOUR_PAIR_BIT] == 1'b0)
    else $error("Reserved offer bits read nonzero");
  complete_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n |=> negotiation_complete == $past(an_done))
    else $error("Completion flag does not follow");
  strap_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !strap_load_q |=> !strap_load_q)
    else $error("Strap reloaded after release");
  turnaround_a: assert property (@(posedge mclk) disable iff (!rst_n)
    read_load |=> mdio_oe && !mdio_o)
    else $error("Turnaround zero not driven");
  release_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (mdc_rise && state_q == ST_DATA && cnt_q == 5'h00) |=> !mdio_oe && state_q == ST_IDLE)
    else $error("Pin not released after frame");
  oe_owner_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mdio_oe |-> read_q && match_q)
    else $error("Pin driven outside own read");
  write_match_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rif.wr |-> match_q && !read_q)
    else $error("Write issued for foreign frame");

endmodule
`default_nettype wire

// file: phy_mgmt_regs_bench.sv
// Self-checking bench for the management register group
`timescale 1ns/100ps
`default_nettype none
module phy_mgmt_regs_bench;
  import mgmt_regs_pkg::*;
  `define check(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
    $display("[FAIL] %0t %s: got %h exp %h", $time, msg, (got), (exp)); end end

  // ****************************************
  // Stimulus signals
  // ****************************************
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic mdc = 1'b0;
  logic host_en = 1'b1;
  logic host_val = 1'b1;
  logic an_done = 1'b0;
  logic [4:0] phy_address = 5'h00;
  logic [3:0] cfg_speed_offer = 4'hf;
  wire mdio_i;
  logic mdio_o;
  logic mdio_oe;
  logic [15:0] negotiation_offer;
  logic negotiation_complete;
  logic [15:0] offer_m;
  int oe_cnt = 0;
  int n_errors = 0;
  int n_tests = 0;
  string msg = "";

  always #20 mclk = ~mclk;
  // Pull-up on the shared data line when nobody drives it
  assign mdio_i = mdio_oe ? mdio_o : (host_en ? host_val : 1'b1);
  always @(posedge mclk) if (mdio_oe === 1'b1) oe_cnt <= oe_cnt + 1;

  phy_mgmt_regs u_dut (
    .mclk(mclk),
    .rst_n(rst_n),
    .mdc(mdc),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe(mdio_oe),
    .phy_address(phy_address),
    .cfg_speed_offer(cfg_speed_offer),
    .an_done(an_done),
    .negotiation_offer(negotiation_offer),
    .negotiation_complete(negotiation_complete)
  );

  // ****************************************
  // Expectations and bus tasks
  // ****************************************
  function automatic logic [15:0] expect_reg(input logic [4:0] a);
    case (a)
      ID_HIGH_ADDR: return VENDOR_ID_HIGH;
      ID_LOW_ADDR: return {VENDOR_ID_LOW_BITS, MODEL_NUMBER, REVISION_NUMBER};
      OFFER_ADDR: return offer_m;
      default: return 16'h0000;
    endcase
  endfunction

  // One bit time: mdc low and high two mclk each, line sampled mid-low
  task automatic mbit(input logic b, input logic drv, output logic s);
    @(posedge mclk);
    mdc <= 1'b0;
    host_en <= drv;
    host_val <= b;
    @(posedge mclk);
    #1 s = mdio_i;
    @(posedge mclk);
    mdc <= 1'b1;
    @(posedge mclk);
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] q);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b01, op, pa, ra};
    q = 16'h0000;
    mbit(1'b1, 1'b1, s);
    mbit(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) mbit(hdr[i], 1'b1, s);
    if (op == OP_WRITE) begin
      mbit(1'b1, 1'b1, s);
      mbit(1'b0, 1'b1, s);
      for (int i = 15; i >= 0; i--) mbit(wd[i], 1'b1, s);
    end else begin
      for (int i = 17; i >= 0; i--) begin
        mbit(1'b1, 1'b0, s);
        if (i < 16) q[i] = s;
      end
    end
    mbit(1'b1, 1'b0, s);
    repeat (3) @(posedge mclk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    frame(OP_WRITE, phy_address, a, d, q);
    // Only the writable offer bits move; fixed ones keep their values
    if (a == OFFER_ADDR) offer_m = (d & 16'hbde0) | 16'h0001;
  endtask

  task automatic do_reset(input logic [3:0] strap);
    @(posedge mclk);
    rst_n <= 1'b0;
    cfg_speed_offer <= strap;
    repeat (2) @(posedge mclk);
    #1 msg = "offer in reset";
    `check(negotiation_offer, 16'h01e1)
    @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    // Strap is only looked at once, so moving it now must change nothing
    cfg_speed_offer <= ~strap;
    #1 offer_m = {7'h00, strap, 5'h01};
    msg = "offer after reset";
    `check(negotiation_offer, offer_m)
    $display("test reset strap %h done", strap);
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    $display("[FAIL] %0t run limit reached", $time);
    conclude();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [15:0] q;
    logic [15:0] pat[$];
    logic [4:0] a;
    int oe_base;
    void'($urandom(32'h9784cabc));
    @(posedge mclk);
    phy_address <= 5'($urandom);
    do_reset(4'($urandom));
    msg = "identifier";
    for (int i = 0; i < 2; i++) begin
      a = (i == 0) ? ID_HIGH_ADDR : ID_LOW_ADDR;
      frame(OP_READ, phy_address, a, 16'h0000, q);
      `check(q, expect_reg(a))
      wr(a, 16'($urandom));
      frame(OP_READ, phy_address, a, 16'h0000, q);
      `check(q, expect_reg(a))
    end
    $display("test identifier done");
    pat = '{16'h8000, 16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h4200, 16'hffff, 16'h0000};
    repeat (6) pat.push_back(16'($urandom));
    msg = "offer";
    foreach (pat[i]) begin
      wr(OFFER_ADDR, pat[i]);
      `check(negotiation_offer, offer_m)
      frame(OP_READ, phy_address, OFFER_ADDR, 16'h0000, q);
      `check(q, offer_m)
    end
    $display("test offer done");
    msg = "unmapped";
    a = 5'(5 + $urandom_range(26));
    wr(a, 16'($urandom));
    frame(OP_READ, phy_address, a, 16'h0000, q);
    `check(q, 16'h0000)
    `check(negotiation_offer, offer_m)
    $display("test unmapped done");
    msg = "foreign address";
    oe_base = oe_cnt;
    frame(OP_WRITE, phy_address ^ 5'h10, OFFER_ADDR, ~offer_m, q);
    frame(OP_READ, phy_address ^ 5'h10, OFFER_ADDR, 16'h0000, q);
    frame(2'b00, phy_address, OFFER_ADDR, 16'h0000, q);
    frame(2'b11, phy_address, OFFER_ADDR, 16'h0000, q);
    `check(oe_cnt, oe_base)
    `check(negotiation_offer, offer_m)
    frame(OP_READ, phy_address, OFFER_ADDR, 16'h0000, q);
    `check(q, offer_m)
    $display("test foreign address done");
    msg = "complete flag";
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      an_done <= (i < 2) ? 1'(i) : 1'($urandom);
      @(posedge mclk);
      #1 `check(negotiation_complete, an_done)
    end
    $display("test complete flag done");
    do_reset(4'h0);
    frame(OP_READ, phy_address, OFFER_ADDR, 16'h0000, q);
    msg = "strap zero";
    `check(q, 16'h0001)
    do_reset(4'hf);
    frame(OP_READ, phy_address, OFFER_ADDR, 16'h0000, q);
    msg = "strap ones";
    `check(q, 16'h01e1)
    conclude();
  end
endmodule
`default_nettype wire
